// ===== hdl/cecenc_field_enc.sv
/*
 * Combinational field encoder: forms the 16-bit compound code.
 * Assumes detector inputs come from logic on the core clock.
 */
`include "cecenc_params.svh"
`default_nettype none
module cecenc_field_enc (
    input wire logic ev_valid_i,
    input wire cecenc_pkg::cecenc_class_type ev_class_i,
    input wire logic ev_filter_i,
    input wire logic ev_uncorrected_i,
    input wire logic ev_level_known_i,
    input wire logic [1:0] hierarchy_level_field_i,
    input wire logic [3:0] request_kind_field_i,
    input wire logic [1:0] transaction_class_field_i,
    input wire logic [1:0] participation_field_i,
    input wire logic req_expired_i,
    input wire logic [1:0] memory_or_io_field_i,
    input wire logic [2:0] memctl_txn_field_i,
    input wire logic ev_chan_known_i,
    input wire logic [3:0] channel_field_i,
    cecenc_fields_if.enc out
);
    // ****************************************
    // Sub-field sanitising
    // ****************************************
    wire logic [1:0] lvl = ev_level_known_i ? hierarchy_level_field_i : `CEC_LVL_GEN;
    wire logic cache_cls = (ev_class_i == cecenc_pkg::CECENC_CACHE);
    wire logic req_rsvd = (request_kind_field_i > `CEC_REQ_SNOOP);
    wire logic req_cache_only = (request_kind_field_i == `CEC_REQ_CAST) || (request_kind_field_i == `CEC_REQ_SNOOP);
    // Bad or cache-only kinds outside caches fall back to generic error
    wire logic [3:0] req = (req_rsvd || (req_cache_only && !cache_cls)) ? `CEC_REQ_ERR
                           : request_kind_field_i;
    wire logic [1:0] tcls = (transaction_class_field_i == 2'h3) ? `CEC_CLS_GEN : transaction_class_field_i;
    wire logic [1:0] mio = (memory_or_io_field_i == `CEC_MIO_RSVD) ? `CEC_MIO_OTHER
                           : memory_or_io_field_i;
    wire logic [2:0] mtx = (memctl_txn_field_i > `CEC_MTX_MAX) ? `CEC_MTX_GEN : memctl_txn_field_i;
    wire logic [3:0] chan = ev_chan_known_i ? channel_field_i : `CEC_CHAN_NONE;
    wire logic t_bit = req_expired_i;
    // Uncorrected events never carry the filter mark
    wire logic f_bit = ev_filter_i && !ev_uncorrected_i;
    // Top nibble of the gen, TLB, memctl, cache and bus forms: filter mark in bit 12
    wire logic [3:0] fz = {3'h0, f_bit};

    // ****************************************
    // Code assembly
    // ****************************************
    wire logic [15:0] c_gen = {fz, 8'h00, 2'h3, lvl};
    wire logic [15:0] c_tlb = {fz, 4'h0, 4'h1, tcls, lvl};
    wire logic [15:0] c_mem = {fz, 4'h0, 1'h1, mtx, chan};
    wire logic [15:0] c_cache = {fz, 4'h1, req, tcls, lvl};
    wire logic [15:0] c_bus = {fz, 1'h1, participation_field_i, t_bit, req, mio, lvl};
    wire logic [15:0] c_scrub = {`CEC_SCRUB_BASE, chan};
    wire logic [15:0] c_wb = `CEC_WB_CODE;

    assign out.arch_error_code = (ev_class_i == cecenc_pkg::CECENC_GEN_CACHE) ? c_gen
                               : (ev_class_i == cecenc_pkg::CECENC_TLB) ? c_tlb
                               : (ev_class_i == cecenc_pkg::CECENC_MEMCTL) ? c_mem
                               : (ev_class_i == cecenc_pkg::CECENC_CACHE) ? c_cache
                               : (ev_class_i == cecenc_pkg::CECENC_BUS) ? c_bus
                               : (ev_class_i == cecenc_pkg::CECENC_SCRUB_UC) ? c_scrub
                               : c_wb;
    assign out.recoverable_optional_class = (ev_class_i == cecenc_pkg::CECENC_SCRUB_UC) ||
                                            (ev_class_i == cecenc_pkg::CECENC_WB_UC);
    assign out.uncorrected = ev_uncorrected_i || out.recoverable_optional_class;
    assign out.valid = ev_valid_i;
endmodule
`default_nettype wire

// ===== hdl/cecenc_log.sv
/*
 * Logging unit: shared bank entry and global status flags.
 * Assumes one event at a time and a software clear pulse from the core clock domain.
 */
`include "cecenc_params.svh"
`default_nettype none
module cecenc_log (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clear_i,
    input wire logic [47:0] ev_addr_i,
    input wire logic [5:0] ev_addr_lsb_i,
    cecenc_fields_if.log in,
    output logic [15:0] arch_error_code_o,
    output logic bank_valid_o,
    output logic overflow_o,
    output logic uncorrected_flag_o,
    output logic address_reg_valid_o,
    output logic extra_info_valid_o,
    output logic context_corrupt_flag_o,
    output logic signaled_o,
    output logic action_required_flag_o,
    output logic [47:0] bank_addr_o,
    output logic [2:0] misc_addr_mode_o,
    output logic [5:0] misc_addr_lsb_o,
    output logic restart_pointer_valid_o,
    output logic error_pointer_valid_o,
    output logic machine_check_signal_o
);
    // ****************************************
    // Entry state
    // ****************************************
    cecenc_pkg::cecenc_state_type state_r;
    cecenc_pkg::cecenc_state_type state_nxt;
    wire logic take = in.valid && (state_r != cecenc_pkg::CECENC_HELD);
    wire logic over = in.valid && (state_r == cecenc_pkg::CECENC_HELD);
    wire logic rao = in.recoverable_optional_class;
    // A clear that meets an event is ignored, so state and valid flag stay in step
    wire logic clr_only = clear_i && !in.valid;

    always_comb begin
        case (state_r)
            cecenc_pkg::CECENC_IDLE: state_nxt = in.valid ? cecenc_pkg::CECENC_LOG : cecenc_pkg::CECENC_IDLE;
            cecenc_pkg::CECENC_LOG: state_nxt = clr_only ? cecenc_pkg::CECENC_IDLE : cecenc_pkg::CECENC_HELD;
            cecenc_pkg::CECENC_HELD: state_nxt = clr_only ? cecenc_pkg::CECENC_IDLE : cecenc_pkg::CECENC_HELD;
            default: state_nxt = cecenc_pkg::CECENC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= cecenc_pkg::CECENC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************
    // Bank and global flags
    // ****************************************
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            arch_error_code_o <= 16'h0000;
            bank_valid_o <= 1'h0;
            overflow_o <= 1'h0;
            uncorrected_flag_o <= 1'h0;
            address_reg_valid_o <= 1'h0;
            extra_info_valid_o <= 1'h0;
            context_corrupt_flag_o <= 1'h0;
            signaled_o <= 1'h0;
            action_required_flag_o <= 1'h0;
            bank_addr_o <= 48'h0;
            misc_addr_mode_o <= 3'h0;
            misc_addr_lsb_o <= 6'h0;
            restart_pointer_valid_o <= 1'h0;
            error_pointer_valid_o <= 1'h0;
            machine_check_signal_o <= 1'h0;
        end else if (take) begin
            arch_error_code_o <= in.arch_error_code;
            bank_valid_o <= 1'h1;
            overflow_o <= 1'h0;
            uncorrected_flag_o <= in.uncorrected;
            address_reg_valid_o <= rao;
            extra_info_valid_o <= rao;
            context_corrupt_flag_o <= 1'h0;
            signaled_o <= rao;
            action_required_flag_o <= 1'h0;
            bank_addr_o <= rao ? ev_addr_i : 48'h0;
            misc_addr_mode_o <= rao ? `CEC_ADDR_MODE_PHYS : 3'h0;
            misc_addr_lsb_o <= rao ? ev_addr_lsb_i : 6'h0;
            restart_pointer_valid_o <= rao;
            error_pointer_valid_o <= 1'h0;
            machine_check_signal_o <= in.uncorrected;
        end else begin
            // A new event outranks the clear; an event that arrives in HELD marks overflow
            if (over) begin
                overflow_o <= 1'h1;
            end else if (clear_i) begin
                bank_valid_o <= 1'h0;
                overflow_o <= 1'h0;
                restart_pointer_valid_o <= 1'h0;
            end
            machine_check_signal_o <= 1'h0;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/cecenc_top.sv
/*
 * Compound error code encoder top: encodes detector reports and logs them in a bank
 * whose valid flag is fanned out to each logical processor enabled in share_mask_i.
 * Assumes detectors drive one event per cycle on the core clock.
 */
`include "cecenc_params.svh"
`default_nettype none
module cecenc_top #(
    parameter int SHARERS = 2
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ev_valid_i,
    input wire cecenc_pkg::cecenc_class_type ev_class_i,
    input wire logic ev_filter_i,
    input wire logic ev_uncorrected_i,
    input wire logic ev_level_known_i,
    input wire logic [1:0] hierarchy_level_field_i,
    input wire logic [3:0] request_kind_field_i,
    input wire logic [1:0] transaction_class_field_i,
    input wire logic [1:0] participation_field_i,
    input wire logic req_expired_i,
    input wire logic [1:0] memory_or_io_field_i,
    input wire logic [2:0] memctl_txn_field_i,
    input wire logic ev_chan_known_i,
    input wire logic [3:0] channel_field_i,
    input wire logic [47:0] ev_addr_i,
    input wire logic [5:0] ev_addr_lsb_i,
    input wire logic clear_i,
    input wire logic [SHARERS-1:0] share_mask_i,
    output logic [15:0] arch_error_code_o,
    output logic bank_valid_o,
    output logic overflow_o,
    output logic uncorrected_flag_o,
    output logic address_reg_valid_o,
    output logic extra_info_valid_o,
    output logic context_corrupt_flag_o,
    output logic signaled_o,
    output logic action_required_flag_o,
    output logic [47:0] bank_addr_o,
    output logic [2:0] misc_addr_mode_o,
    output logic [5:0] misc_addr_lsb_o,
    output logic restart_pointer_valid_o,
    output logic error_pointer_valid_o,
    output logic machine_check_signal_o,
    output logic [SHARERS-1:0] sharer_sees_entry_o,
    output logic [SHARERS-1:0] sharer_mc_o
);
    cecenc_fields_if fields ();
    logic bank_valid_w;
    logic mc_w;

    cecenc_field_enc u_enc (
        .ev_valid_i(ev_valid_i),
        .ev_class_i(ev_class_i),
        .ev_filter_i(ev_filter_i),
        .ev_uncorrected_i(ev_uncorrected_i),
        .ev_level_known_i(ev_level_known_i),
        .hierarchy_level_field_i(hierarchy_level_field_i),
        .request_kind_field_i(request_kind_field_i),
        .transaction_class_field_i(transaction_class_field_i),
        .participation_field_i(participation_field_i),
        .req_expired_i(req_expired_i),
        .memory_or_io_field_i(memory_or_io_field_i),
        .memctl_txn_field_i(memctl_txn_field_i),
        .ev_chan_known_i(ev_chan_known_i),
        .channel_field_i(channel_field_i),
        .out(fields)
    );

    cecenc_log u_log (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .clear_i(clear_i),
        .ev_addr_i(ev_addr_i),
        .ev_addr_lsb_i(ev_addr_lsb_i),
        .in(fields),
        .arch_error_code_o(arch_error_code_o),
        .bank_valid_o(bank_valid_w),
        .overflow_o(overflow_o),
        .uncorrected_flag_o(uncorrected_flag_o),
        .address_reg_valid_o(address_reg_valid_o),
        .extra_info_valid_o(extra_info_valid_o),
        .context_corrupt_flag_o(context_corrupt_flag_o),
        .signaled_o(signaled_o),
        .action_required_flag_o(action_required_flag_o),
        .bank_addr_o(bank_addr_o),
        .misc_addr_mode_o(misc_addr_mode_o),
        .misc_addr_lsb_o(misc_addr_lsb_o),
        .restart_pointer_valid_o(restart_pointer_valid_o),
        .error_pointer_valid_o(error_pointer_valid_o),
        .machine_check_signal_o(mc_w)
    );

    assign bank_valid_o = bank_valid_w;
    assign machine_check_signal_o = mc_w;

    // ****************************************
    // Sharing and broadcast
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < SHARERS; g++) begin : g_share
            always_ff @(posedge core_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    sharer_sees_entry_o[g] <= 1'h0;
                    sharer_mc_o[g] <= 1'h0;
                end else begin
                    sharer_sees_entry_o[g] <= bank_valid_w && share_mask_i[g];
                    sharer_mc_o[g] <= mc_w;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ===== inc/cecenc_fields_if.sv
/*
 * Carries a sanitised error report from the field encoder to the logging unit.
 * Both ends run on the same clock.
 */
`default_nettype none
interface cecenc_fields_if;
    logic [15:0] arch_error_code;
    logic recoverable_optional_class;
    logic uncorrected;
    logic valid;
    modport enc (output arch_error_code, output recoverable_optional_class, output uncorrected, output valid);
    modport log (input arch_error_code, input recoverable_optional_class, input uncorrected, input valid);
endinterface
`default_nettype wire

// ===== inc/cecenc_params.svh
/*
 * Field positions, encodings and fixed values of the compound error code encoder.
 * Included by the design modules; holds definitions only.
 */
`ifndef CECENC_PARAMS_SVH
`define CECENC_PARAMS_SVH

// Code layout
`define CEC_FILTER_BIT 12
`define CEC_CODE_W 16
// Hierarchy level
`define CEC_LVL_L0 2'h0
`define CEC_LVL_L1 2'h1
`define CEC_LVL_L2 2'h2
`define CEC_LVL_GEN 2'h3
// Request kinds
`define CEC_REQ_ERR 4'h0
`define CEC_REQ_RD 4'h1
`define CEC_REQ_WR 4'h2
`define CEC_REQ_DATA_RD 4'h3
`define CEC_REQ_DATA_WR 4'h4
`define CEC_REQ_FETCH 4'h5
`define CEC_REQ_PREF 4'h6
`define CEC_REQ_CAST 4'h7
`define CEC_REQ_SNOOP 4'h8
// Transaction class
`define CEC_CLS_INSTR 2'h0
`define CEC_CLS_DATA 2'h1
`define CEC_CLS_GEN 2'h2
// Participation
`define CEC_PART_ORIG 2'h0
`define CEC_PART_RESP 2'h1
`define CEC_PART_SEEN 2'h2
`define CEC_PART_GEN 2'h3
// Memory or I/O
`define CEC_MIO_MEM 2'h0
`define CEC_MIO_RSVD 2'h1
`define CEC_MIO_IO 2'h2
`define CEC_MIO_OTHER 2'h3
// Memory controller transaction
`define CEC_MTX_GEN 3'h0
`define CEC_MTX_SCRUB 3'h4
`define CEC_MTX_MAX 3'h4
`define CEC_CHAN_NONE 4'hf
// Fixed prefixes of the compound forms
`define CEC_PFX_GENCACHE 12'h000
`define CEC_PFX_TLB 10'h001
`define CEC_PFX_CACHE 8'h01
// Recoverable optional codes
`define CEC_SCRUB_BASE 12'h00c
`define CEC_WB_CODE 16'h017a
// Misc register physical address mode
`define CEC_ADDR_MODE_PHYS 3'h2
`endif

// ===== inc/cecenc_pkg.sv
/*
 * Types of the compound error code encoder.
 * Uses no definitions from cecenc_params.svh.
 */
`default_nettype none
package cecenc_pkg;
    typedef enum logic [2:0] {
        CECENC_GEN_CACHE = 3'h0,
        CECENC_TLB = 3'h1,
        CECENC_MEMCTL = 3'h2,
        CECENC_CACHE = 3'h3,
        CECENC_BUS = 3'h4,
        CECENC_SCRUB_UC = 3'h5,
        CECENC_WB_UC = 3'h6
    } cecenc_class_type;

    typedef enum logic [1:0] {
        CECENC_IDLE = 2'h0,
        CECENC_LOG = 2'h1,
        CECENC_HELD = 2'h2
    } cecenc_state_type;
endpackage
`default_nettype wire

// ===== testbench/cecenc_det_model.sv
/*
 * Error detector model: offers one report at a time to the encoder.
 * Assumes the core clock; every change lands on its falling edge.
 */
`default_nettype none
module cecenc_det_model (
    input wire logic clk_i,
    output logic ev_valid_o,
    output cecenc_pkg::cecenc_class_type ev_class_o,
    output logic [23:0] fld_o,
    output logic [53:0] addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************
    // Report driver
    // ********************************
    initial begin
        ev_valid_o = 1'b0;
        ev_class_o = cecenc_pkg::CECENC_GEN_CACHE;
        fld_o = 24'h0;
        addr_o = 54'h0;
    end
    // Fields are inverted once released so a stale value never looks like a report
    task automatic fire(input logic [2:0] cls, input logic [23:0] fld, input logic [53:0] addr);
        @(negedge clk_i);
        ev_valid_o = 1'b1;
        ev_class_o = cecenc_pkg::cecenc_class_type'(cls);
        fld_o = fld;
        addr_o = addr;
        @(negedge clk_i);
        ev_valid_o = 1'b0;
        fld_o = ~fld;
        addr_o = ~addr;
    endtask
endmodule
`default_nettype wire

// ===== testbench/cecenc_top_sva.sv
/*
 * Concurrent checks on the ports of the compound error code encoder top.
 * Assumes one core clock and the active-low asynchronous reset of the design.
 */
`default_nettype none
module cecenc_top_sva #(
    parameter int SHARERS = 2
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ev_valid_i,
    input wire logic ev_uncorrected_i,
    input wire logic [SHARERS-1:0] share_mask_i,
    input wire logic [15:0] arch_error_code_o,
    input wire logic bank_valid_o,
    input wire logic overflow_o,
    input wire logic uncorrected_flag_o,
    input wire logic address_reg_valid_o,
    input wire logic extra_info_valid_o,
    input wire logic context_corrupt_flag_o,
    input wire logic signaled_o,
    input wire logic action_required_flag_o,
    input wire logic [2:0] misc_addr_mode_o,
    input wire logic restart_pointer_valid_o,
    input wire logic error_pointer_valid_o,
    input wire logic machine_check_signal_o,
    input wire logic [SHARERS-1:0] sharer_sees_entry_o,
    input wire logic [SHARERS-1:0] sharer_mc_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // ********************************
    // Sequences and checks
    // ********************************
    sequence unc_taken;
        ev_valid_i && !bank_valid_o && ev_uncorrected_i;
    endsequence
    sequence mc_bcast;
        machine_check_signal_o ##1 (&sharer_mc_o);
    endsequence
    sequence opt_held;
        bank_valid_o && address_reg_valid_o;
    endsequence
    mc_follow_a: assert property (unc_taken |=> mc_bcast) else $error("no broadcast");
    mc_cause_a: assert property (machine_check_signal_o |-> bank_valid_o && uncorrected_flag_o)
        else $error("stray broadcast");
    log_answer_a: assert property (ev_valid_i && !bank_valid_o |=> bank_valid_o) else $error("no entry");
    share_view_a: assert property (bank_valid_o ##1 bank_valid_o |-> sharer_sees_entry_o == share_mask_i)
        else $error("sharer view wrong");
    share_none_a: assert property (!bank_valid_o |=> sharer_sees_entry_o == '0) else $error("stale view");
    opt_code_a: assert property (opt_held |-> arch_error_code_o[15:4] == 12'h00c || arch_error_code_o == 16'h017a)
        else $error("addr valid on other code");
    opt_flags_a: assert property (opt_held |-> uncorrected_flag_o && extra_info_valid_o && signaled_o
        && !context_corrupt_flag_o && !action_required_flag_o && misc_addr_mode_o == 3'h2)
        else $error("status flags wrong");
    restart_ptr_a: assert property (opt_held |-> restart_pointer_valid_o && !error_pointer_valid_o)
        else $error("pointer flags wrong");
    unc_post_a: assert property (bank_valid_o && uncorrected_flag_o |-> !arch_error_code_o[12])
        else $error("filter on uncorrected");
    code_top_a: assert property (bank_valid_o |-> arch_error_code_o[15:13] == 3'h0) else $error("top bits");
    no_rsvd_a: assert property (bank_valid_o |-> !(arch_error_code_o[11] && arch_error_code_o[3:2] == 2'h1)
        && !(arch_error_code_o[11:7] == 5'h01 && arch_error_code_o[6:4] > 3'h4)
        && !((arch_error_code_o[11] || arch_error_code_o[11:8] == 4'h1) && arch_error_code_o[7:4] > 4'h8))
        else $error("reserved encoding");
    refuse_keep_a: assert property ($rose(overflow_o) |-> $stable(arch_error_code_o))
        else $error("refused event changed code");
endmodule
bind cecenc_top cecenc_top_sva #(.SHARERS(SHARERS)) i_cecenc_top_sva (.core_clk_i, .resetn_i, .ev_valid_i,
    .ev_uncorrected_i, .share_mask_i, .arch_error_code_o, .bank_valid_o, .overflow_o, .uncorrected_flag_o,
    .address_reg_valid_o, .extra_info_valid_o, .context_corrupt_flag_o, .signaled_o, .action_required_flag_o,
    .misc_addr_mode_o, .restart_pointer_valid_o, .error_pointer_valid_o, .machine_check_signal_o,
    .sharer_sees_entry_o, .sharer_mc_o);
`default_nettype wire

// ===== testbench/testbench.sv
/*
 * Self-checking bench for the compound error code encoder top.
 * Assumes the detector model and the bound checker are compiled alongside.
 */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic clear_i = 1'b0;
    logic [1:0] share_mask_i = 2'h3;
    logic ev_valid;
    cecenc_pkg::cecenc_class_type ev_class;
    logic [23:0] f;
    logic [53:0] a;
    logic [15:0] arch_error_code_o;
    logic bank_valid_o, overflow_o, uncorrected_flag_o, address_reg_valid_o, extra_info_valid_o;
    logic context_corrupt_flag_o, signaled_o, action_required_flag_o, restart_pointer_valid_o;
    logic error_pointer_valid_o, machine_check_signal_o;
    logic [47:0] bank_addr_o;
    logic [2:0] misc_addr_mode_o;
    logic [5:0] misc_addr_lsb_o;
    logic [1:0] sharer_sees_entry_o, sharer_mc_o;
    int fail_count = 0;
    int n_checks = 0;
    cecenc_det_model i_cecenc_det_model (.clk_i(core_clk_i), .ev_valid_o(ev_valid), .ev_class_o(ev_class),
        .fld_o(f), .addr_o(a));
    cecenc_top i_cecenc_top (.core_clk_i, .resetn_i, .ev_valid_i(ev_valid), .ev_class_i(ev_class),
        .ev_filter_i(f[23]), .ev_uncorrected_i(f[22]), .ev_level_known_i(f[21]),
        .hierarchy_level_field_i(f[20:19]), .request_kind_field_i(f[18:15]), .transaction_class_field_i(f[14:13]),
        .participation_field_i(f[12:11]), .req_expired_i(f[10]), .memory_or_io_field_i(f[9:8]),
        .memctl_txn_field_i(f[7:5]), .ev_chan_known_i(f[4]), .channel_field_i(f[3:0]), .ev_addr_i(a[47:0]),
        .ev_addr_lsb_i(a[53:48]), .clear_i, .share_mask_i, .arch_error_code_o, .bank_valid_o, .overflow_o,
        .uncorrected_flag_o, .address_reg_valid_o, .extra_info_valid_o, .context_corrupt_flag_o, .signaled_o,
        .action_required_flag_o, .bank_addr_o, .misc_addr_mode_o, .misc_addr_lsb_o, .restart_pointer_valid_o,
        .error_pointer_valid_o, .machine_check_signal_o, .sharer_sees_entry_o, .sharer_mc_o);
    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end
    // ********************************
    // Access tasks
    // ********************************
    task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic final_report();
        if (fail_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    function automatic logic [23:0] mk(logic u, fl, lk, logic [1:0] lv, logic [3:0] rq, logic [1:0] tc, pa,
        logic t, logic [1:0] mi, logic [2:0] mm, logic ck, logic [3:0] ch);
        return {fl, u, lk, lv, rq, tc, pa, t, mi, mm, ck, ch};
    endfunction
    task automatic clr();
        clear_i = 1'b1;
        @(negedge core_clk_i);
        clear_i = 1'b0;
        chk("cleared", {bank_valid_o, overflow_o, restart_pointer_valid_o}, 3'h0);
    endtask
    task automatic ev(input logic [2:0] c, input logic [23:0] fv, input logic [15:0] e, input logic keep = 1'b0);
        logic opt;
        logic [53:0] ad;
        opt = c > 3'h4;
        ad = {3'h0, c, 45'h1234_5678_9ab, c};
        i_cecenc_det_model.fire(c, fv, ad);
        chk("code", {bank_valid_o, arch_error_code_o}, {1'b1, e});
        chk("flags", {uncorrected_flag_o, address_reg_valid_o, extra_info_valid_o, context_corrupt_flag_o,
            signaled_o, action_required_flag_o, restart_pointer_valid_o, error_pointer_valid_o,
            misc_addr_mode_o}, opt ? 11'h752 : {fv[22], 10'h0});
        if (opt) chk("addr", {misc_addr_lsb_o, bank_addr_o}, ad);
        chk("mc", machine_check_signal_o, fv[22]);
        @(negedge core_clk_i);
        chk("sharers", {machine_check_signal_o, sharer_mc_o, sharer_sees_entry_o},
            {1'b0, {2{fv[22]}}, share_mask_i});
        if (!keep) clr();
    endtask
    // ********************************
    // Scenarios
    // ********************************
    initial begin
        repeat (20) @(negedge core_clk_i);
        chk("reset", {bank_valid_o, arch_error_code_o, machine_check_signal_o}, 18'h0);
        resetn_i = 1'b1;
        ev(5, mk(1, 0, 1, 0, 0, 0, 0, 0, 0, 4, 1, 3), 16'h00c3);
        share_mask_i = 2'h1;
        ev(5, mk(1, 0, 1, 0, 0, 0, 0, 0, 0, 4, 0, 5), 16'h00cf);
        ev(6, mk(1, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0), 16'h017a);
        for (int i = 0; i < 9; i++) ev(3, mk(0, 1, 1, 1, i[3:0], 1, 0, 0, 0, 0, 0, 0),
            {8'h11, i[3:0], 4'h5});
        ev(3, mk(1, 1, 1, 0, 3, 0, 0, 0, 0, 0, 0, 0), 16'h0130);
        ev(3, mk(0, 0, 1, 0, 4'hf, 0, 0, 0, 0, 0, 0, 0), 16'h0100);
        for (int i = 0; i < 4; i++) ev(0, mk(0, 0, 1, i[1:0], 0, 0, 0, 0, 0, 0, 0, 0), {14'h0003, i[1:0]});
        ev(0, mk(0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0), 16'h000f);
        for (int i = 0; i < 4; i++) ev(1, mk(0, 0, 1, 1, 0, i[1:0], 0, 0, 0, 0, 0, 0),
            {12'h001, (i == 3) ? 2'h2 : i[1:0], 2'h1});
        for (int i = 0; i < 4; i++) ev(4, mk(0, 0, 1, 2, 1, 0, i[1:0], i[0], i[1:0], 0, 0, 0),
            {5'h01, i[1:0], i[0], 4'h1, (i == 1) ? 2'h3 : i[1:0], 2'h2});
        for (int i = 7; i < 10; i++) ev(4, mk(0, 0, 1, 0, i[3:0], 0, 0, 0, 0, 0, 0, 0), 16'h0800);
        for (int i = 0; i < 8; i++) ev(2, mk(0, 0, 0, 0, 0, 0, 0, 0, 0, i[2:0], 1, i[3:0]),
            {9'h001, (i > 4) ? 3'h0 : i[2:0], i[3:0]});
        ev(2, mk(0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 4'he), 16'h009e);
        ev(2, mk(0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 4'h2), 16'h108f);
        ev(5, mk(1, 0, 1, 0, 0, 0, 0, 0, 0, 4, 1, 1), 16'h00c1, 1'b1);
        i_cecenc_det_model.fire(6, mk(1, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0), 54'h0);
        chk("refused", {overflow_o, arch_error_code_o, bank_addr_o[7:0]}, {1'b1, 16'h00c1, 8'h5d});
        clr();
        final_report();
    end
endmodule
`default_nettype wire
